// *** rtl/flash_id_suspend_secreg_cmds.sv ***
// serial flash command interpreter: id reads, suspend/resume, security erase
`timescale 1ns/1ps

// What this block does
// - ABH alone leaves power-down after release delay
// - ID form outputs device ID after dummies
// - ID form releases after second delay
// - release/ID ignored while write in progress
// - 90H gives maker/device, address picks order
// - 92H same read over two lines
// - 94H same read over four lines
// - 9FH gives maker, type, capacity bytes
// - 9FH not decoded during program/erase
// - select rise stops output, back to standby
// - suspend accepted only while running, unsuspended
// - suspend flag at once, busy drops later
// - program suspend refuses writes, erases, programs
// - erase suspend refuses writes and erases
// - power loss clears suspended state
// - resume clears flag, busy within 200ns
// - 44H needs latch, address, exact end
// - security erase self-timed, clears write latch
// - locked security register ignores erase
// - security address fields select register
// - power-down ignores all but release, reset
module flash_id_suspend_secreg_cmds #(
    parameter logic [31:0] ERASE_CYCLES = flash_cmd_pkg::ERASE_CYCLES_DEFAULT,
    parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
    parameter logic [7:0] DEVICE_ID = 8'h13, // arbitrary value
    parameter logic [7:0] MEM_TYPE = 8'h60, // arbitrary value
    parameter logic [7:0] CAPACITY = 8'h14   // arbitrary value
) (
    // core clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // serial link
    input wire logic linkClk,
    input wire logic csN,
    input wire logic [3:0] ioIn,
    output logic [3:0] ioOut,
    output logic [3:0] ioOeN,
    // program/erase engine and status register
    input wire logic engineBusy,
    input wire logic engineIsErase,
    input wire logic writeEnableLatch,
    input wire logic [2:0] securityLockBits,
    input wire logic powerGood,
    output logic pauseEngine,
    output logic welClear,
    output logic secEraseStart,
    output logic [1:0] secEraseSel,
    // status and command hand-off
    output flash_cmd_pkg::status_t status,
    output flash_cmd_pkg::power_t powerMode,
    output logic passValid,
    output logic [7:0] passOp,
    output logic cmdRefused
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // data lanes used by an opcode
    function automatic logic [2:0] lanes(input logic [7:0] op);
        case (op)
            flash_cmd_pkg::OP_MAKER_ID_DUAL: lanes = 3'h2;
            flash_cmd_pkg::OP_MAKER_ID_QUAD: lanes = 3'h4;
            default: lanes = 3'h1;
        endcase
    endfunction

    // frame clocks, opcode included, until the id data starts
    function automatic logic [5:0] dataStart(input logic [7:0] op);
        case (op)
            flash_cmd_pkg::OP_RELEASE: dataStart = flash_cmd_pkg::ADDR_FRAME_CLOCKS;
            flash_cmd_pkg::OP_IDENT: dataStart = flash_cmd_pkg::OPCODE_CLOCKS;
            default: dataStart = 6'(flash_cmd_pkg::OPCODE_CLOCKS + 6'(24 / lanes(op)));
        endcase
    endfunction

    // rotate the output pattern by one clock's worth of lanes
    function automatic logic [47:0] rot(input logic [47:0] p, input logic [2:0] n);
        case (n)
            3'h2: rot = {p[45:0], p[47:46]};
            3'h4: rot = {p[43:0], p[47:44]};
            default: rot = {p[46:0], p[47]};
        endcase
    endfunction

    // ----------------------------------------
    // link domain: frame capture
    // ----------------------------------------
    flash_cmd_pkg::frame_t frame_ff; // quasi-static once select rises
    logic firstBit_ff; // next rising edge opens a frame
    logic linkClear; // releases the pins outside frames
    logic [2:0] flagMeta_ff; // first synchroniser stage
    logic [2:0] flagLink_ff; // wip, down, wake seen by link
    logic [2:0] nLanes; // lanes of current opcode
    logic idOp; // opcode outputs an id
    logic idAllowed; // id output not blocked
    logic dataPhase; // id bits are due
    logic [47:0] pattern; // id bytes repeated to 48 bits
    logic [47:0] pat_ff; // rotating output pattern
    logic outOn_ff; // first id bits already out

    assign linkClear = csN | ~rst_n;
    assign nLanes = lanes(frame_ff.op);

    // marks the first clock of a frame
    always_ff @(posedge linkClk or posedge csN)
    begin
        if (csN)
            firstBit_ff <= 1'b1;
        else
            firstBit_ff <= 1'b0;
    end

    // opcode then address, MSB first on rising edges
    always_ff @(posedge linkClk or negedge rst_n)
    begin
        if (!rst_n)
            frame_ff <= '0;
        else if (firstBit_ff)
        begin
            frame_ff.op <= {7'h00, ioIn[0]};
            frame_ff.clocks <= 6'h01;
            frame_ff.addr <= '0;
        end
        else
        begin
            if (frame_ff.clocks != flash_cmd_pkg::CLOCKS_MAX)
                frame_ff.clocks <= frame_ff.clocks + 6'h01;
            if (frame_ff.clocks < flash_cmd_pkg::OPCODE_CLOCKS)
                frame_ff.op <= {frame_ff.op[6:0], ioIn[0]};
            else if (frame_ff.clocks < 6'(flash_cmd_pkg::OPCODE_CLOCKS + 6'(24 / nLanes)))
            begin
                // address on one, two or four lanes
                case (nLanes)
                    3'h2: frame_ff.addr <= {frame_ff.addr[21:0], ioIn[1:0]};
                    3'h4: frame_ff.addr <= {frame_ff.addr[19:0], ioIn[3:0]};
                    default: frame_ff.addr <= {frame_ff.addr[22:0], ioIn[0]};
                endcase
            end
        end
    end

    // core flags brought into the link domain
    always_ff @(posedge linkClk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flagMeta_ff <= '0;
            flagLink_ff <= '0;
        end
        else
        begin
            flagMeta_ff <= {status.write_in_progress_flag, powerMode == flash_cmd_pkg::PM_DOWN, powerMode == flash_cmd_pkg::PM_WAKE};
            flagLink_ff <= flagMeta_ff;
        end
    end

    // ----------------------------------------
    // link domain: id output
    // ----------------------------------------
    // which id bytes go out and whether they may
    always_comb
    begin
        idOp = 1'b0;
        idAllowed = ~flagLink_ff[0]; // nothing during wake-up
        pattern = {6{DEVICE_ID}};
        case (frame_ff.op)
            flash_cmd_pkg::OP_RELEASE:
            begin
                idOp = 1'b1;
                idAllowed = ~flagLink_ff[2] & ~flagLink_ff[0];
            end
            flash_cmd_pkg::OP_IDENT:
            begin
                idOp = 1'b1;
                idAllowed = ~flagLink_ff[2] & ~flagLink_ff[1] & ~flagLink_ff[0];
                pattern = {2{MAKER_ID, MEM_TYPE, CAPACITY}};
            end
            flash_cmd_pkg::OP_MAKER_ID, flash_cmd_pkg::OP_MAKER_ID_DUAL, flash_cmd_pkg::OP_MAKER_ID_QUAD:
            begin
                idOp = 1'b1;
                idAllowed = ~flagLink_ff[1] & ~flagLink_ff[0];
                // address bit 0 picks which id leads
                pattern = frame_ff.addr[0] ? {3{DEVICE_ID, MAKER_ID}} : {3{MAKER_ID, DEVICE_ID}};
            end
            default:
            begin
                idOp = 1'b0;
            end
        endcase
    end

    assign dataPhase = idOp & idAllowed & (frame_ff.clocks >= dataStart(frame_ff.op));

    // falling-edge shifter, repeats until select rises
    always_ff @(negedge linkClk or posedge linkClear)
    begin
        if (linkClear)
        begin
            outOn_ff <= 1'b0;
            pat_ff <= '0;
            ioOut <= 4'h0;
            ioOeN <= 4'hf; // pins released, standby
        end
        else if (dataPhase)
        begin
            outOn_ff <= 1'b1;
            pat_ff <= rot(outOn_ff ? pat_ff : pattern, nLanes);
            // MSB first on the falling edge
            case (nLanes)
                3'h2:
                begin
                    ioOut <= {2'h0, outOn_ff ? pat_ff[47:46] : pattern[47:46]};
                    ioOeN <= 4'hc;
                end
                3'h4:
                begin
                    ioOut <= outOn_ff ? pat_ff[47:44] : pattern[47:44];
                    ioOeN <= 4'h0;
                end
                default:
                begin
                    ioOut <= {2'h0, outOn_ff ? pat_ff[47] : pattern[47], 1'b0};
                    ioOeN <= 4'hd;
                end
            endcase
        end
    end

    // ----------------------------------------
    // core domain: frame end detection
    // ----------------------------------------
    logic [1:0] csSync_ff; // select synchroniser
    logic csPrev_ff; // previous synced select
    logic [1:0] pwrSync_ff; // power-good synchroniser
    logic csRise; // frame just ended
    logic powerLost; // supply gone
    logic singleByte; // frame held exactly an opcode
    logic susAny; // either suspend flag
    logic suspendRefused; // opcode barred by suspend
    logic [3:0] secField; // register select field
    logic secAddrOk; // valid security address
    logic [1:0] secIdx; // register number minus one
    flash_cmd_pkg::frame_t f; // frame seen at select rise
    localparam int SEC_SEL_MSB = flash_cmd_pkg::SEC_SEL_LSB + 3;

    // select and power-good crossings
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            csSync_ff <= 2'h3;
            csPrev_ff <= 1'b1;
            pwrSync_ff <= 2'h0;
        end
        else
        begin
            csSync_ff <= {csSync_ff[0], csN};
            csPrev_ff <= csSync_ff[1];
            pwrSync_ff <= {pwrSync_ff[0], powerGood};
        end
    end

    assign csRise = csSync_ff[1] & ~csPrev_ff;
    assign powerLost = ~pwrSync_ff[1];
    assign f = frame_ff;
    assign singleByte = f.clocks == flash_cmd_pkg::OPCODE_CLOCKS;
    assign susAny = |status.suspend;
    assign secField = f.addr[SEC_SEL_MSB:flash_cmd_pkg::SEC_SEL_LSB];
    assign secIdx = 2'(secField - 4'h1);
    // upper byte zero, gap bits zero, select 1..3
    assign secAddrOk = (f.addr[23:16] == flash_cmd_pkg::SEC_UPPER) & (f.addr[11:9] == flash_cmd_pkg::SEC_GAP)
                       & (secField != 4'h0) & (secField < 4'h4);

    // opcodes barred while suspended
    always_comb
    begin
        suspendRefused = 1'b0;
        case (f.op)
            flash_cmd_pkg::OP_WRITE_STATUS, flash_cmd_pkg::OP_SEC_ERASE, flash_cmd_pkg::OP_SECTOR_ERASE,
            flash_cmd_pkg::OP_BLOCK32_ERASE, flash_cmd_pkg::OP_BLOCK64_ERASE, flash_cmd_pkg::OP_CHIP_ERASE_A,
            flash_cmd_pkg::OP_CHIP_ERASE_B:
                suspendRefused = susAny;
            flash_cmd_pkg::OP_SEC_PROG, flash_cmd_pkg::OP_PAGE_PROG, flash_cmd_pkg::OP_QUAD_PROG:
                suspendRefused = status.suspend[1];
            default:
                suspendRefused = 1'b0;
        endcase
    end

    // ----------------------------------------
    // core domain: power-down and release
    // ----------------------------------------
    logic [11:0] wakeCnt_ff; // release delay left

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            powerMode <= flash_cmd_pkg::PM_ACTIVE;
            wakeCnt_ff <= '0;
        end
        else if (powerLost)
            powerMode <= flash_cmd_pkg::PM_ACTIVE;
        else
        begin
            case (powerMode)
                flash_cmd_pkg::PM_ACTIVE:
                    if (csRise && singleByte && f.op == flash_cmd_pkg::OP_POWER_DOWN && !status.write_in_progress_flag)
                        powerMode <= flash_cmd_pkg::PM_DOWN;
                flash_cmd_pkg::PM_DOWN:
                    // release alone or with the id form
                    if (csRise && f.op == flash_cmd_pkg::OP_RELEASE && !status.write_in_progress_flag)
                    begin
                        if (singleByte)
                        begin
                            powerMode <= flash_cmd_pkg::PM_WAKE;
                            wakeCnt_ff <= flash_cmd_pkg::RELEASE_CYCLES;
                        end
                        else if (f.clocks >= flash_cmd_pkg::ADDR_FRAME_CLOCKS)
                        begin
                            powerMode <= flash_cmd_pkg::PM_WAKE;
                            wakeCnt_ff <= flash_cmd_pkg::RELEASE_ID_CYCLES;
                        end
                    end
                flash_cmd_pkg::PM_WAKE:
                    // commands wait out the delay
                    if (wakeCnt_ff <= 12'h001)
                        powerMode <= flash_cmd_pkg::PM_ACTIVE;
                    else
                        wakeCnt_ff <= wakeCnt_ff - 12'h001;
                default:
                    powerMode <= flash_cmd_pkg::PM_ACTIVE;
            endcase
        end
    end

    // ----------------------------------------
    // core domain: suspend, resume, busy flag
    // ----------------------------------------
    logic [1:0] susp_ff; // suspend flags
    logic wip_ff; // busy flag
    logic [11:0] susCnt_ff; // suspend latency left
    logic [11:0] resumeCnt_ff; // busy held until engine restarts, at most RESUME_CYCLES
    logic [31:0] secCnt_ff; // security erase time left
    logic secBusy_ff; // security erase running
    assign status = {wip_ff, susp_ff};

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            susp_ff <= 2'h0;
            pauseEngine <= 1'b0;
            susCnt_ff <= '0;
            resumeCnt_ff <= '0;
        end
        else if (powerLost)
        begin
            susp_ff <= 2'h0;
            pauseEngine <= 1'b0;
            resumeCnt_ff <= '0;
        end
        else if (csRise && singleByte && powerMode == flash_cmd_pkg::PM_ACTIVE
                 && f.op == flash_cmd_pkg::OP_SUSPEND && !susAny && status.write_in_progress_flag && engineBusy)
        begin
            // flag set at once, engine asked to stop
            susp_ff <= engineIsErase ? 2'h1 : 2'h2;
            pauseEngine <= 1'b1;
            susCnt_ff <= flash_cmd_pkg::SUSPEND_CYCLES;
        end
        else if (csRise && singleByte && powerMode == flash_cmd_pkg::PM_ACTIVE
                 && f.op == flash_cmd_pkg::OP_RESUME && susAny && !status.write_in_progress_flag)
        begin
            // flag cleared, busy raised next cycle
            susp_ff <= 2'h0;
            pauseEngine <= 1'b0;
            resumeCnt_ff <= flash_cmd_pkg::RESUME_CYCLES;
        end
        else
        begin
            if (susCnt_ff != 12'h000)
                susCnt_ff <= susCnt_ff - 12'h001;
            if (resumeCnt_ff != 12'h000 && !engineBusy)
                resumeCnt_ff <= resumeCnt_ff - 12'h001;
            else
                resumeCnt_ff <= '0;
        end
    end

    // busy flag, forced low once suspend latency runs out
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            wip_ff <= 1'b0;
        else
            wip_ff <= secBusy_ff | (resumeCnt_ff != 12'h000) | (engineBusy & ~(susAny & susCnt_ff == 12'h000));
    end

    // ----------------------------------------
    // core domain: security register erase
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            secBusy_ff <= 1'b0;
            secCnt_ff <= '0;
            welClear <= 1'b0;
            secEraseStart <= 1'b0;
            secEraseSel <= 2'h0;
        end
        else if (csRise && f.op == flash_cmd_pkg::OP_SEC_ERASE && f.clocks == flash_cmd_pkg::ADDR_FRAME_CLOCKS
                 && writeEnableLatch && !status.write_in_progress_flag && !susAny && powerMode == flash_cmd_pkg::PM_ACTIVE
                 && secAddrOk && !securityLockBits[secIdx])
        begin
            // self-timed cycle starts at select rise
            secBusy_ff <= 1'b1;
            secCnt_ff <= ERASE_CYCLES;
            welClear <= 1'b1;
            secEraseStart <= 1'b1;
            secEraseSel <= secIdx;
        end
        else
        begin
            welClear <= 1'b0;
            secEraseStart <= 1'b0;
            if (secCnt_ff > 32'h1)
                secCnt_ff <= secCnt_ff - 32'h1;
            else
                secBusy_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // core domain: hand-off of other opcodes
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            passValid <= 1'b0;
            passOp <= 8'h00;
            cmdRefused <= 1'b0;
        end
        else
        begin
            passValid <= 1'b0;
            cmdRefused <= 1'b0;
            if (csRise && f.clocks != 6'h00)
            begin
                passOp <= f.op;
                if (suspendRefused)
                    cmdRefused <= 1'b1;
                else if (powerMode == flash_cmd_pkg::PM_WAKE)
                    cmdRefused <= 1'b1;
                else if (powerMode == flash_cmd_pkg::PM_DOWN)
                    // only reset passes while powered down
                    if (f.op == flash_cmd_pkg::OP_RESET_ENABLE || f.op == flash_cmd_pkg::OP_RESET)
                        passValid <= 1'b1;
                    else
                        cmdRefused <= f.op != flash_cmd_pkg::OP_RELEASE;
                else
                    passValid <= 1'b1;
            end
        end
    end

endmodule

// *** rtl/flash_cmd_pkg.sv ***
// shared opcodes, timing counts and carrier types for the flash command block
package flash_cmd_pkg;
    // opcodes handled or screened by the block
    localparam logic [7:0] OP_RELEASE = 8'hab;
    localparam logic [7:0] OP_MAKER_ID = 8'h90;
    localparam logic [7:0] OP_MAKER_ID_DUAL = 8'h92;
    localparam logic [7:0] OP_MAKER_ID_QUAD = 8'h94;
    localparam logic [7:0] OP_IDENT = 8'h9f;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7a;
    localparam logic [7:0] OP_SEC_ERASE = 8'h44;
    localparam logic [7:0] OP_SEC_PROG = 8'h42;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
    localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
    localparam logic [7:0] OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] OP_QUAD_PROG = 8'h32;
    localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
    localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
    localparam logic [7:0] OP_RESET = 8'h99;
    // frame lengths in serial clocks
    localparam logic [5:0] OPCODE_CLOCKS = 6'h08;
    localparam logic [5:0] ADDR_FRAME_CLOCKS = 6'h20;
    localparam logic [5:0] CLOCKS_MAX = 6'h3f;
    // security register address layout
    localparam logic [7:0] SEC_UPPER = 8'h00;
    localparam logic [2:0] SEC_GAP = 3'h0;
    localparam int SEC_SEL_LSB = 12;
    // timing, core clock 100 MHz
    localparam int CLK_PERIOD_NS = 10;
    localparam int RELEASE_DELAY_NS = 3000;
    localparam int RELEASE_ID_DELAY_NS = 1800;
    localparam int SUSPEND_MAX_NS = 20000;
    localparam int RESUME_MAX_NS = 200;
    localparam int ERASE_CYCLE_TIME_US = 50000;
    localparam int COUNT_W = 12;
    // least times round up, longest times round down
    localparam logic [11:0] RELEASE_CYCLES = 12'((RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] RELEASE_ID_CYCLES = 12'((RELEASE_ID_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] SUSPEND_CYCLES = 12'(SUSPEND_MAX_NS / CLK_PERIOD_NS);
    localparam logic [11:0] RESUME_CYCLES = 12'(RESUME_MAX_NS / CLK_PERIOD_NS);
    localparam logic [31:0] ERASE_CYCLES_DEFAULT = 32'(ERASE_CYCLE_TIME_US * 1000 / CLK_PERIOD_NS);
    // captured serial frame
    typedef struct packed {
        logic [7:0] op;
        logic [5:0] clocks;
        logic [23:0] addr;
    } frame_t;
    // status flags, suspend[1] program, suspend[0] erase
    typedef struct packed {
        logic write_in_progress_flag;
        logic [1:0] suspend;
    } status_t;
    // power state
    typedef enum logic [1:0] {
        PM_ACTIVE = 2'b00,
        PM_DOWN = 2'b01,
        PM_WAKE = 2'b10
    } power_t;
endpackage

// *** sim/flash_id_suspend_secreg_cmds_props.sv ***
// port assertions for the flash command block
`timescale 1ns/1ps
module flash_id_suspend_secreg_cmds_props (
    // clock, reset and inputs
    input wire logic clock,
    input wire logic rst_n,
    input wire logic csN,
    input wire logic [2:0] securityLockBits,
    input wire logic powerGood,
    // watched outputs
    input wire logic [3:0] ioOeN,
    input wire logic welClear,
    input wire logic secEraseStart,
    input wire logic [1:0] secEraseSel,
    input wire flash_cmd_pkg::status_t status,
    input wire flash_cmd_pkg::power_t powerMode,
    input wire logic passValid,
    input wire logic [7:0] passOp
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_pair; secEraseStart |-> welClear; endproperty
    a_pair: assert property (p_pair) else $error("erase without clear");
    property p_busy; secEraseStart |=> status.write_in_progress_flag; endproperty
    a_busy: assert property (p_busy) else $error("erase not busy");
    property p_lock; secEraseStart |-> !securityLockBits[secEraseSel]; endproperty
    a_lock: assert property (p_lock) else $error("locked register erased");
    property p_resume; $fell(|status.suspend) && $past(powerGood, 3) |=> status.write_in_progress_flag; endproperty
    a_resume: assert property (p_resume) else $error("resume not busy");
    property p_susp; $rose(|status.suspend) |-> $past(status.write_in_progress_flag); endproperty
    a_susp: assert property (p_susp) else $error("suspend while idle");
    property p_idle; csN |-> ioOeN == 4'hf; endproperty
    a_idle: assert property (p_idle) else $error("pins driven when idle");
    property p_down;
        passValid && $past(powerMode) == flash_cmd_pkg::PM_DOWN |-> passOp inside {8'h66, 8'h99};
    endproperty
    a_down: assert property (p_down) else $error("passed in power-down");
    property p_refuse;
        passValid && $past(status.suspend) != 2'h0 |-> !(passOp inside {8'h01, 8'h44, 8'h20, 8'h52, 8'hd8});
    endproperty
    a_refuse: assert property (p_refuse) else $error("passed while suspended");
    c_erase: cover property (secEraseStart);
    c_susp: cover property ($rose(status.suspend[0]));
    c_wake: cover property (powerMode == flash_cmd_pkg::PM_WAKE);
endmodule
bind flash_id_suspend_secreg_cmds flash_id_suspend_secreg_cmds_props props (.clock, .rst_n, .csN,
    .securityLockBits, .powerGood, .ioOeN, .welClear, .secEraseStart, .secEraseSel, .status,
    .powerMode, .passValid, .passOp);

// *** sim/spi_host_model.sv ***
// host spi controller model, mode 0, link clock idles low
`timescale 1ns/1ps
module spi_host_model (
    // link pins
    output logic linkClk,
    output logic csN,
    output logic [3:0] ioIn,
    input wire logic [3:0] ioOut
);
    initial
    begin
        linkClk = 1'b0;
        csN = 1'b1;
        ioIn = 4'h0;
    end
    // nTx bits out on io0 msb first, then nRx bits in from io1
    task automatic xfer(input logic [31:0] tx, input int nTx, input int nRx, output logic [23:0] rx);
        rx = 24'h0;
        csN = 1'b0;
        for (int i = 0; i < nTx + nRx; i++)
        begin
            ioIn = {~ioIn[3:1], (i < nTx) ? tx[31 - i] : ~ioIn[0]}; // unused lines wobble
            #24;
            if (i >= nTx) rx = {rx[22:0], ioOut[1]};
            linkClk = 1'b1;
            #24 linkClk = 1'b0;
        end
        #24 csN = 1'b1; // select rises after the last bit
    endtask
endmodule

// *** sim/flash_id_suspend_secreg_cmds_bench.sv ***
// self-checking bench for the flash command block
`timescale 1ns/1ps
module flash_id_suspend_secreg_cmds_bench;
    localparam logic [7:0] MID = 8'h5a; // arbitrary value
    localparam logic [7:0] DID = 8'h13; // arbitrary value
    logic clock, rst_n, linkClk, csN, engineBusy, engineIsErase, writeEnableLatch, powerGood;
    logic [3:0] ioIn, ioOut, ioOeN;
    logic [2:0] securityLockBits;
    logic pauseEngine, welClear, secEraseStart, passValid, cmdRefused, startSeen, refSeen;
    logic [1:0] secEraseSel, selSeen;
    logic [7:0] passOp;
    logic [8:0] lowBits;
    logic [23:0] rx;
    flash_cmd_pkg::status_t status;
    flash_cmd_pkg::power_t powerMode;
    int seed = 86029;
    int bad_count = 0;
    int n_checks = 0;
    flash_id_suspend_secreg_cmds #(.ERASE_CYCLES(32'h32), .MAKER_ID(MID), .DEVICE_ID(DID), .MEM_TYPE(8'h60),
        .CAPACITY(8'h14)) dut (.clock, .rst_n, .linkClk, .csN, .ioIn, .ioOut, .ioOeN, .engineBusy,
        .engineIsErase, .writeEnableLatch, .securityLockBits, .powerGood, .pauseEngine, .welClear,
        .secEraseStart, .secEraseSel, .status, .powerMode, .passValid, .passOp, .cmdRefused);
    spi_host_model host (.linkClk, .csN, .ioIn, .ioOut);
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // latch one-cycle pulses
    always @(posedge clock)
    begin
        if (secEraseStart) startSeen <= 1'b1;
        if (secEraseStart) selSeen <= secEraseSel;
        if (cmdRefused) refSeen <= 1'b1;
    end
    task automatic check(input string nm, input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) bad_count++;
        if (got !== exp) $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    endtask
    task automatic frame(input logic [31:0] tx, input int nTx, input int nRx);
        startSeen = 1'b0;
        refSeen = 1'b0;
        host.xfer(tx, nTx, nRx, rx);
        repeat (8) @(negedge clock);
    endtask
    function automatic logic [23:0] id_pair(input logic a0);
        return a0 ? {8'h0, DID, MID} : {8'h0, MID, DID};
    endfunction
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        #500us bad_count++;
        final_report();
    end
    initial
    begin
        {rst_n, engineBusy, engineIsErase, startSeen, refSeen, selSeen, securityLockBits} = 0;
        {writeEnableLatch, powerGood} = 2'h3;
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        frame({8'h9f, 24'h0}, 8, 24);
        check("ident", rx, {MID, 8'h60, 8'h14});
        for (int a = 0; a < 2; a++)
        begin
            frame({8'h90, 23'h0, a[0]}, 32, 16);
            check("maker", rx, id_pair(a[0]));
        end
        frame({8'hab, 24'h0}, 32, 16);
        check("rdi", rx, {8'h0, DID, DID});
        $display("test ids done");
        for (int s = 1; s < 4; s++)
        begin
            securityLockBits = 3'($random(seed));
            lowBits = 9'($random(seed));
            frame({8'h44, 8'h00, 4'(s), 3'h0, lowBits}, 32, 0);
            check("erase", {23'h0, startSeen}, {23'h0, !securityLockBits[s - 1]});
            if (startSeen) check("sel", {22'h0, selSeen}, 24'(s - 1));
            repeat (60) @(negedge clock);
        end
        securityLockBits = 3'h0;
        for (int k = 0; k < 2; k++)
        begin
            frame({8'h44, 8'h00, 4'h1, k[0] ? 3'h1 : 3'h0, 9'h0}, k[0] ? 32 : 31, 0);
            check("bad erase", {23'h0, startSeen}, 24'h0);
        end
        $display("test erase done");
        frame({8'h75, 24'h0}, 8, 0);
        check("idle suspend", {22'h0, status.suspend}, 24'h0);
        engineIsErase = 1'b1;
        engineBusy = 1'b1;
        repeat (4) @(negedge clock);
        frame({8'h75, 24'h0}, 8, 0);
        check("suspend", {22'h0, status.suspend}, 24'h1);
        check("pause", {23'h0, pauseEngine}, 24'h1);
        engineBusy = 1'b0;
        repeat (4) @(negedge clock);
        frame({8'h44, 8'h00, 4'h1, 12'h0}, 32, 0);
        check("refused", {23'h0, refSeen}, 24'h1);
        frame({8'h7a, 24'h0}, 8, 0);
        check("resume", {22'h0, status.suspend}, 24'h0);
        engineBusy = 1'b1;
        repeat (4) @(negedge clock);
        engineBusy = 1'b0;
        repeat (30) @(negedge clock);
        $display("test suspend done");
        frame({8'hb9, 24'h0}, 8, 0);
        check("down", 24'(powerMode), 24'(flash_cmd_pkg::PM_DOWN));
        frame({8'h66, 24'h0}, 8, 0);
        check("pass", {16'h0, passOp}, 24'h66);
        frame({8'hab, 24'h0}, 8, 0);
        check("waking", 24'(powerMode), 24'(flash_cmd_pkg::PM_WAKE));
        repeat (310) @(negedge clock); // select held high meanwhile
        check("awake", 24'(powerMode), 24'(flash_cmd_pkg::PM_ACTIVE));
        $display("test power done");
        final_report();
    end
endmodule
